// [rtl/dtc_timer_pair.sv]
// Dual four-mode timer/counter with an AHB-Lite register slave.
//
// Notes on behaviour
// - Each unit is a timer or an event counter, by its function-select bit.
// - Two-bit mode field; modes 0-2 alike, mode 3 differs per unit.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 0 counts 13 bits: high byte plus low five low-byte bits.
// - Wrap from all ones to zero sets that unit's overflow flag.
// - Counting needs run control set and gate clear or gate pin high.
// - Setting run control keeps the count; counting resumes from it.
// - Unit one gate is mode bit 7, unit zero gate is bit 3.
// - Mode 1 is mode 0 using the full 16 bits.
// - Mode 2: low byte counts, overflow sets flag, reloads from high.
// - Unit one in mode 3 holds its count as if stopped.
// - Split mode: unit zero low byte uses all unit zero controls.
// - Split mode: unit zero high byte times, uses unit one run, flag.
// - Split mode: unit one still counts, but never sets its flag.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_timer_pair (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timer pins
    input wire logic unit0_count_pin,
    input wire logic unit1_count_pin,
    input wire logic unit0_gate_pin,
    input wire logic unit1_gate_pin,
    // Interrupt
    output logic irq
);

    // ********************************
    // Step function
    // ********************************
    function automatic dtc_pkg::dtc_step_t step(
        input dtc_pkg::dtc_mode_t mode,
        input dtc_pkg::dtc_cnt_t c
    );
        dtc_pkg::dtc_step_t r;
        logic [12:0] v13;
        logic [15:0] v16;
        r.cnt = c;
        r.ovf = 1'b0;
        v13 = {c.hi, c.lo[4:0]} + 13'h0001;
        v16 = {c.hi, c.lo} + 16'h0001;
        unique case (mode)
            dtc_pkg::DTC_MODE13:
            begin
                // Low five bits act as the divide-by-32 stage.
                r.cnt.hi = v13[12:5];
                r.cnt.lo = {c.lo[7:5], v13[4:0]};
                r.ovf = &{c.hi, c.lo[4:0]};
            end
            dtc_pkg::DTC_MODE16:
            begin
                r.cnt = v16;
                r.ovf = &{c.hi, c.lo};
            end
            dtc_pkg::DTC_MODE8R:
            begin
                r.ovf = &c.lo;
                r.cnt.lo = r.ovf ? c.hi : c.lo + 8'h01;
            end
            dtc_pkg::DTC_MODESPLIT:
            begin
                r.ovf = &c.lo;
                r.cnt.lo = c.lo + 8'h01;
            end
        endcase
        return r;
    endfunction

    // ********************************
    // Bus slave
    // ********************************
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic hready_q;
    logic hresp_q;
    logic [31:0] hrdata_q;
    logic [7:0] rdata;

    wire addr_ok = hsel & htrans[1] & hready;
    wire wr_mode = wr_pend_q & (addr_q == `DTC_OFS_MODE);
    wire wr_ctrl = wr_pend_q & (addr_q == `DTC_OFS_CTRL);
    wire wr_l0 = wr_pend_q & (addr_q == `DTC_OFS_U0_LO);
    wire wr_h0 = wr_pend_q & (addr_q == `DTC_OFS_U0_HI);
    wire wr_l1 = wr_pend_q & (addr_q == `DTC_OFS_U1_LO);
    wire wr_h1 = wr_pend_q & (addr_q == `DTC_OFS_U1_HI);
    wire wr_stat = wr_pend_q & (addr_q == `DTC_OFS_STAT);
    wire wr_mask = wr_pend_q & (addr_q == `DTC_OFS_MASK);
    wire [7:0] wdat = hwdata[7:0];

    // Reads take one wait state so that a write just before is seen.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= addr_ok & hwrite;
            rd_pend_q <= addr_ok & ~hwrite;
            hready_q <= ~(addr_ok & ~hwrite);
            if (addr_ok)
            begin
                addr_q <= {haddr[7:2], 2'b00};
            end
            if (rd_pend_q)
            begin
                hrdata_q <= {24'h00_0000, rdata};
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = hresp_q;

    // ********************************
    // Control registers
    // ********************************
    logic [7:0] mode_q;
    logic run0_q;
    logic run1_q;
    logic [1:0] ovf_q;
    logic [1:0] mask_q;
    logic irq_q;

    dtc_pkg::dtc_cfg_t cfg0;
    dtc_pkg::dtc_cfg_t cfg1;
    assign cfg0 = dtc_pkg::dtc_cfg_t'(mode_q[`DTC_MODE_U0_LSB +: 4]);
    assign cfg1 = dtc_pkg::dtc_cfg_t'(mode_q[`DTC_MODE_U1_LSB +: 4]);
    wire split = (cfg0.mode == dtc_pkg::DTC_MODESPLIT);

    // ********************************
    // Pins and machine cycle
    // ********************************
    logic mc_en;
    logic [3:0] pin_lvl;
    logic [1:0] cnt_prev_q;

    dtc_cycle_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .mc_en(mc_en)
    );

    dtc_pin_sync #(.N(4)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({unit1_gate_pin, unit0_gate_pin, unit1_count_pin,
            unit0_count_pin}),
        .lvl(pin_lvl)
    );

    // Count pins are sampled once per machine cycle, so a pulse shorter
    // than a machine cycle on either level may be missed.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_prev_q <= 2'h0;
        end
        else if (mc_en)
        begin
            cnt_prev_q <= pin_lvl[1:0];
        end
    end

    wire [1:0] fall = cnt_prev_q & ~pin_lvl[1:0];

    // ********************************
    // Count enables
    // ********************************
    wire en0 = run0_q & (~cfg0.gate | pin_lvl[2]);
    wire en1 = run1_q & (~cfg1.gate | pin_lvl[3])
        & (cfg1.mode != dtc_pkg::DTC_MODESPLIT);
    wire src0 = cfg0.ctr ? fall[0] : 1'b1;
    wire src1 = cfg1.ctr ? fall[1] : 1'b1;
    wire tick0 = mc_en & en0 & src0;
    wire tick1 = mc_en & en1 & src1;
    wire tickh0 = mc_en & run1_q & split;

    // ********************************
    // Counters
    // ********************************
    dtc_pkg::dtc_cnt_t cnt0_q;
    dtc_pkg::dtc_cnt_t cnt1_q;
    dtc_pkg::dtc_cnt_t cnt0_d;
    dtc_pkg::dtc_cnt_t cnt1_d;
    dtc_pkg::dtc_step_t s0;
    dtc_pkg::dtc_step_t s1;

    assign s0 = step(cfg0.mode, cnt0_q);
    // Unit one never sees mode 3 as a counting mode, so treat it as mode 1 when unit zero is split.
    assign s1 = step(split && cfg1.mode == dtc_pkg::DTC_MODESPLIT ?
        dtc_pkg::DTC_MODE16 : cfg1.mode, cnt1_q);

    wire hi0_wrap = tickh0 & (&cnt0_q.hi);
    wire [1:0] set = {(tick1 & s1.ovf & ~split) | hi0_wrap,
        tick0 & s0.ovf};
    wire [1:0] clr = wr_stat ? wdat[1:0] : 2'h0;
    wire [1:0] ovf_d = set | (ovf_q & ~clr);

    // Software writes win over a count step in the same cycle.
    always_comb
    begin
        cnt0_d = cnt0_q;
        cnt1_d = cnt1_q;
        if (tick0)
        begin
            cnt0_d = s0.cnt;
        end
        if (tickh0)
        begin
            cnt0_d.hi = cnt0_q.hi + 8'h01;
        end
        if (tick1)
        begin
            cnt1_d = s1.cnt;
        end
        if (wr_l0)
        begin
            cnt0_d.lo = wdat;
        end
        if (wr_h0)
        begin
            cnt0_d.hi = wdat;
        end
        if (wr_l1)
        begin
            cnt1_d.lo = wdat;
        end
        if (wr_h1)
        begin
            cnt1_d.hi = wdat;
        end
    end

    // Run control writes touch no count byte.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt0_q <= {`DTC_RST_BYTE, `DTC_RST_BYTE};
            cnt1_q <= {`DTC_RST_BYTE, `DTC_RST_BYTE};
            mode_q <= `DTC_RST_BYTE;
            run0_q <= 1'b0;
            run1_q <= 1'b0;
            ovf_q <= `DTC_RST_FLAGS;
            mask_q <= `DTC_RST_FLAGS;
            irq_q <= 1'b0;
        end
        else
        begin
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
            mode_q <= wr_mode ? wdat : mode_q;
            run0_q <= wr_ctrl ? wdat[`DTC_CTRL_RUN0_BIT] : run0_q;
            run1_q <= wr_ctrl ? wdat[`DTC_CTRL_RUN1_BIT] : run1_q;
            ovf_q <= ovf_d;
            mask_q <= wr_mask ? wdat[1:0] : mask_q;
            irq_q <= |(ovf_d & mask_q);
        end
    end

    assign irq = irq_q;

    // ********************************
    // Read mux
    // ********************************
    logic [7:0] ctrl_rd;
    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[`DTC_CTRL_RUN0_BIT] = run0_q;
        ctrl_rd[`DTC_CTRL_OVF0_BIT] = ovf_q[0];
        ctrl_rd[`DTC_CTRL_RUN1_BIT] = run1_q;
        ctrl_rd[`DTC_CTRL_OVF1_BIT] = ovf_q[1];
    end

    assign rdata =
        (addr_q == `DTC_OFS_MODE) ? mode_q :
        (addr_q == `DTC_OFS_CTRL) ? ctrl_rd :
        (addr_q == `DTC_OFS_U0_LO) ? cnt0_q.lo :
        (addr_q == `DTC_OFS_U0_HI) ? cnt0_q.hi :
        (addr_q == `DTC_OFS_U1_LO) ? cnt1_q.lo :
        (addr_q == `DTC_OFS_U1_HI) ? cnt1_q.hi :
        (addr_q == `DTC_OFS_STAT) ? {6'h00, ovf_q} :
        (addr_q == `DTC_OFS_MASK) ? {6'h00, mask_q} : 8'h00;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_ovf0_set: assert property (tick0 && s0.ovf |=> ovf_q[0])
        else $error("unit0 wrap did not set its flag");

    a_mode2_reload: assert property (
        tick0 && cfg0.mode == dtc_pkg::DTC_MODE8R && cnt0_q.lo == 8'hFF
        && !wr_l0 && !wr_h0
        |=> cnt0_q.lo == $past(cnt0_q.hi) && $stable(cnt0_q.hi))
        else $error("mode 2 reload wrong");

    a_unit1_hold: assert property (
        (!run1_q || cfg1.mode == dtc_pkg::DTC_MODESPLIT)
        && !wr_l1 && !wr_h1 |=> $stable(cnt1_q))
        else $error("unit1 moved while stopped");

    a_gate_block: assert property (
        cfg0.gate && !pin_lvl[2] && !wr_l0 |=> $stable(cnt0_q.lo))
        else $error("unit0 counted while gated");

    a_mode16_step: assert property (
        tick0 && cfg0.mode == dtc_pkg::DTC_MODE16 && !wr_l0 && !wr_h0
        |=> {cnt0_q.hi, cnt0_q.lo} == $past({cnt0_q.hi, cnt0_q.lo})
        + 16'h0001)
        else $error("mode 1 step wrong");

    a_mode13_top: assert property (
        tick0 && cfg0.mode == dtc_pkg::DTC_MODE13 && !wr_l0
        |=> cnt0_q.lo[7:5] == $past(cnt0_q.lo[7:5]))
        else $error("mode 0 touched upper low bits");

    a_split_high: assert property (
        tickh0 && !wr_h0 |=> cnt0_q.hi == $past(cnt0_q.hi) + 8'h01)
        else $error("split high byte did not step");

    a_split_noflag: assert property (
        split && !hi0_wrap |=> !$rose(ovf_q[1]))
        else $error("unit1 flag set in split mode");

    a_irq_level: assert property (
        (ovf_q & mask_q) != 2'h0 && clr == 2'h0 |=> irq_q)
        else $error("irq missing for unmasked flag");

    c_split_wrap: cover property (hi0_wrap);
    c_mode2_wrap: cover property (
        tick0 && s0.ovf && cfg0.mode == dtc_pkg::DTC_MODE8R);
    c_pin_count: cover property (tick1 && cfg1.ctr);

endmodule

// [rtl/dtc_params.svh]
// Offsets, field positions, reset values and timing counts of the timer pair.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ********************************
// Register byte offsets
// ********************************
`define DTC_OFS_MODE 8'h00
`define DTC_OFS_CTRL 8'h04
`define DTC_OFS_U0_LO 8'h08
`define DTC_OFS_U0_HI 8'h0C
`define DTC_OFS_U1_LO 8'h10
`define DTC_OFS_U1_HI 8'h14
`define DTC_OFS_STAT 8'h18
`define DTC_OFS_MASK 8'h1C

// ********************************
// Field positions
// ********************************
`define DTC_MODE_U0_LSB 0
`define DTC_MODE_U1_LSB 4
`define DTC_GATE_U0_BIT 3
`define DTC_GATE_U1_BIT 7
`define DTC_CTRL_RUN0_BIT 4
`define DTC_CTRL_OVF0_BIT 5
`define DTC_CTRL_RUN1_BIT 6
`define DTC_CTRL_OVF1_BIT 7

// ********************************
// Reset values
// ********************************
`define DTC_RST_BYTE 8'h00
`define DTC_RST_FLAGS 2'h0

// ********************************
// Timing
// ********************************
`define DTC_HCLK_HZ 20000000
`define DTC_MCYC_CLKS 12

`endif

// [rtl/dtc_pkg.sv]
// Types shared by the timer pair.
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE13,
        DTC_MODE16,
        DTC_MODE8R,
        DTC_MODESPLIT
    } dtc_mode_t;

    // One nibble of the mode register: gate, function select, mode.
    typedef struct packed {
        logic gate;
        logic ctr;
        dtc_mode_t mode;
    } dtc_cfg_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } dtc_cnt_t;

    typedef struct packed {
        dtc_cnt_t cnt;
        logic ovf;
    } dtc_step_t;

endpackage

// [rtl/dtc_pin_sync.sv]
// Three-flop synchroniser with agreement filter for the timer pins.
`timescale 1ns/100ps
module dtc_pin_sync #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pins and filtered levels
    input wire logic [N-1:0] pin,
    output logic [N-1:0] lvl
);

    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] lvl_q;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_pin
            // The level only moves once two settled stages agree.
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    lvl_q[i] <= 1'b0;
                end
                else
                begin
                    s1_q[i] <= pin[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i])
                    begin
                        lvl_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign lvl = lvl_q;

endmodule

// [rtl/dtc_cycle_div.sv]
// Machine-cycle enable divider for the timer pair.
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_cycle_div (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // One-cycle pulse per machine cycle
    output logic mc_en
);

    localparam logic [3:0] LAST = 4'(`DTC_MCYC_CLKS - 1);

    logic [3:0] cnt_q;
    logic en_q;
    wire wrap = (cnt_q == LAST);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 4'h0;
            en_q <= 1'b0;
        end
        else
        begin
            cnt_q <= wrap ? 4'h0 : cnt_q + 4'h1;
            en_q <= wrap;
        end
    end

    assign mc_en = en_q;

endmodule

// [tb/dtc_pin_model.sv]
// Partner model that drives the count and gate pins of the timer pair.
`timescale 1ns/100ps
module dtc_pin_model (
    // Clock
    input wire logic hclk,
    // Pins toward the timer pair
    output logic [1:0] count_pin,
    output logic [1:0] gate_pin
);
    // Each level is held longer than one machine cycle plus the filter
    // delay, so a fall can never slip between two samples unseen.
    localparam int HOLD = 20;

    initial
    begin
        count_pin = 2'h3;
        gate_pin = 2'h0;
    end

    task automatic set_gate(input int u, input logic v);
        @(posedge hclk);
        gate_pin[u] <= v;
    endtask

    // One falling edge on the chosen count pin, then back to high.
    task automatic pulse(input int u);
        @(posedge hclk);
        count_pin[u] <= 1'b0;
        repeat (HOLD) @(posedge hclk);
        count_pin[u] <= 1'b1;
        repeat (HOLD) @(posedge hclk);
    endtask
endmodule

// [tb/dtc_timer_pair_tb_top.sv]
// Self-checking testbench of the timer pair.
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_timer_pair_tb_top;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [1:0] count_pin;
    logic [1:0] gate_pin;
    logic irq;
    logic [7:0] rd;
    int n_errors;
    int check_count;
    int cycles;

    always #25 hclk = ~hclk;

    dtc_timer_pair dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .unit0_count_pin(count_pin[0]),
        .unit1_count_pin(count_pin[1]), .unit0_gate_pin(gate_pin[0]),
        .unit1_gate_pin(gate_pin[1]), .irq(irq));

    dtc_pin_model pin_u (
        .hclk(hclk), .count_pin(count_pin), .gate_pin(gate_pin));

    // ********************************
    // Bus cycles and comparison
    // ********************************
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
        chk({7'h00, hresp}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00, rd);
        chk(rd, e);
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Presets a count pair, starts it and polls the flag; the stop write
    // lands well inside one machine cycle, so no further step is taken.
    task automatic run_to_ovf(input logic [7:0] mcfg, input logic [7:0] b,
                              input logic [7:0] lo, input logic [7:0] hi,
                              input logic [7:0] run, input int fb);
        int n;
        wr(`DTC_OFS_MODE, mcfg);
        wr(b, lo);
        wr(b + 8'h04, hi);
        wr(`DTC_OFS_CTRL, run);
        n = 0;
        rd = 8'h00;
        while (rd[fb] !== 1'b1 && n < 50)
        begin
            xfer(`DTC_OFS_STAT, 1'b0, 8'h00, rd);
            n++;
        end
        wr(`DTC_OFS_CTRL, 8'h00);
    endtask

    // The run should need about 1100 cycles; a hang ends it far later.
    always @(posedge hclk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            n_errors++;
            conclude();
        end
    end

    // ********************************
    // Scenarios
    // ********************************
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        wr(8'h24, 8'hFF);
        for (int a = 0; a < 12; a++) rdchk(8'(4 * a), 8'h00);
        wr(`DTC_OFS_MASK, 8'h03);
        // Modes 0 to 2 on both units, each through its wrap.
        for (int u = 0; u < 2; u++)
        begin
            for (int m = 0; m < 3; m++)
            begin
                run_to_ovf(8'(m << (4 * u)), 8'(8 + 8 * u), 8'hFF,
                    m == 2 ? 8'h80 : 8'hFF, 8'(16 << (2 * u)), u);
                chk(rd, 8'(1 << u));
                chk({7'h00, irq}, 8'h01);
                xfer(8'(8 + 8 * u), 1'b0, 8'h00, rd);
                chk(rd & (m == 0 ? 8'h1F : 8'hFF), m == 2 ? 8'h80 : 8'h00);
                rdchk(8'(12 + 8 * u), m == 2 ? 8'h80 : 8'h00);
                wr(`DTC_OFS_STAT, 8'h03);
                rdchk(`DTC_OFS_STAT, 8'h00);
                chk({7'h00, irq}, 8'h00);
            end
        end
        // A masked flag leaves the interrupt low until unmasked.
        wr(`DTC_OFS_MASK, 8'h00);
        run_to_ovf(8'h01, `DTC_OFS_U0_LO, 8'hFF, 8'hFF, 8'h10, 0);
        chk({7'h00, irq}, 8'h00);
        rdchk(`DTC_OFS_CTRL, 8'h20);
        wr(`DTC_OFS_MASK, 8'h01);
        rdchk(`DTC_OFS_STAT, 8'h01);
        chk({7'h00, irq}, 8'h01);
        wr(`DTC_OFS_STAT, 8'h03);
        // Gate bits: unit zero at bit 3, unit one at bit 7.
        for (int u = 0; u < 2; u++)
        begin
            wr(`DTC_OFS_MODE, 8'(9 << (4 * u)));
            wr(8'(8 + 8 * u), 8'h00);
            wr(`DTC_OFS_CTRL, 8'(16 << (2 * u)));
            repeat (60) @(posedge hclk);
            rdchk(8'(8 + 8 * u), 8'h00);
            pin_u.set_gate(u, 1'b1);
            repeat (60) @(posedge hclk);
            wr(`DTC_OFS_CTRL, 8'h00);
            pin_u.set_gate(u, 1'b0);
            xfer(8'(8 + 8 * u), 1'b0, 8'h00, rd);
            chk({7'h00, rd != 8'h00}, 8'h01);
        end
        // Counter function: three pin falls give three counts.
        for (int u = 0; u < 2; u++)
        begin
            wr(`DTC_OFS_MODE, 8'(5 << (4 * u)));
            wr(8'(8 + 8 * u), 8'h00);
            wr(`DTC_OFS_CTRL, 8'(16 << (2 * u)));
            repeat (3) pin_u.pulse(u);
            wr(`DTC_OFS_CTRL, 8'h00);
            rdchk(8'(8 + 8 * u), 8'h03);
        end
        // Unit one in mode 3 holds its count although run is set.
        wr(`DTC_OFS_MODE, 8'h30);
        wr(`DTC_OFS_U1_LO, 8'h05);
        wr(`DTC_OFS_CTRL, 8'h40);
        repeat (60) @(posedge hclk);
        wr(`DTC_OFS_CTRL, 8'h00);
        rdchk(`DTC_OFS_U1_LO, 8'h05);
        // Split mode: high byte on unit one's run and flag.
        wr(`DTC_OFS_U0_LO, 8'h10);
        run_to_ovf(8'h33, `DTC_OFS_U0_HI, 8'hFF, 8'hFF, 8'h40, 1);
        chk(rd, 8'h02);
        rdchk(`DTC_OFS_U0_LO, 8'h10);
        wr(`DTC_OFS_STAT, 8'h03);
        run_to_ovf(8'h33, `DTC_OFS_U0_LO, 8'hFF, 8'h00, 8'h10, 0);
        chk(rd, 8'h01);
        rdchk(`DTC_OFS_U0_HI, 8'h00);
        wr(`DTC_OFS_STAT, 8'h03);
        // Split mode: unit one still counts but never raises its flag.
        wr(`DTC_OFS_MODE, 8'h13);
        wr(`DTC_OFS_U1_LO, 8'hFE);
        wr(`DTC_OFS_U1_HI, 8'hFF);
        wr(`DTC_OFS_CTRL, 8'h40);
        repeat (48) @(posedge hclk);
        wr(`DTC_OFS_CTRL, 8'h00);
        xfer(`DTC_OFS_U1_LO, 1'b0, 8'h00, rd);
        chk({7'h00, rd != 8'hFE}, 8'h01);
        rdchk(`DTC_OFS_STAT, 8'h00);
        conclude();
    end
endmodule
